/* File: hdl/pmc_ctrl.sv */
`default_nettype none
module pmc_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_save_instruction,
    input wire logic [7:0] save_operand,
    input wire logic [2:0] clk_src_sel,
    input wire logic irq_pending,
    input wire logic wdt_enable,
    input wire logic wdt_timeout,
    input wire logic calendar_enable,
    input wire logic calendar_on_lpo,
    input wire logic calendar_alarm,
    input wire logic clock_fail_monitor_en,
    input wire logic ds_watchdog_enable,
    input wire logic ds_watchdog_timeout,
    input wire logic supply_por,
    input wire logic brownout_event,
    input wire logic deep_brownout_cfg_enable,
    input wire logic master_clear_pin_n,
    input wire logic ext_irq_zero,
    input wire logic ext_irq_zero_en,
    input wire logic ext_irq_zero_pol,
    output logic sys_clk_en,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic low_power_osc_run,
    output logic io_freeze,
    output logic mem_power_en,
    output logic wdt_clear,
    output logic irq_holdoff,
    output logic irq_discard,
    output logic cpu_reset,
    output logic [2:0] resume_clk_src
);
    ////////////////////////////////////////////////////////////////////////
    // State and storage
    pmc_pkg::pmc_state_t state_q;
    pmc_pkg::pmc_state_t state_d;
    logic idle_sel_q;
    logic arm_q;
    logic [3:0] arm_cnt_q;
    logic [7:0] por_cnt_q;
    logic unfreeze_q;
    logic ext_en_q;
    logic ext_prev_q;
    logic [pmc_pkg::SCRATCH_W-1:0] scratch_a_q;
    logic [pmc_pkg::SCRATCH_W-1:0] scratch_b_q;
    logic [2:0] clk_src_q;
    logic [pmc_pkg::WS_NUM-1:0] ws_set;
    logic [pmc_pkg::WS_NUM-1:0] ws_q;
    logic exit_flag_q;
    logic bor_flag_q;
    logic wr_en;
    logic wr_ctrl;
    logic ext_assert;
    logic ext_wake;
    logic ds_wake;
    logic ds_lost;
    logic ds_entry;
    logic sleep_wake;

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign wr_ctrl = wr_en && (paddr == pmc_pkg::DS_CTRL_OFS);

    // Unmapped addresses answer with an error and zero data
    always_comb begin
        pslverr = 1'b0;
        case (paddr)
            pmc_pkg::DS_CTRL_OFS, pmc_pkg::WAKE_SRC_OFS,
            pmc_pkg::RST_CAUSE_OFS, pmc_pkg::SCRATCH_A_OFS,
            pmc_pkg::SCRATCH_B_OFS, pmc_pkg::STATUS_OFS: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    // Read data registered at the setup phase so it is flop-driven
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata <= pmc_pkg::RDATA_RST;
        end else if (psel && !penable && !pwrite) begin
            prdata <= pmc_pkg::RDATA_RST;
            case (paddr)
                pmc_pkg::DS_CTRL_OFS: begin
                    prdata[pmc_pkg::ARM_BIT] <= arm_q;
                    prdata[pmc_pkg::BROWNOUT_BIT] <= bor_flag_q;
                    prdata[pmc_pkg::UNFREEZE_BIT] <= unfreeze_q;
                end
                pmc_pkg::WAKE_SRC_OFS: prdata[pmc_pkg::WS_NUM-1:0] <= ws_q;
                pmc_pkg::RST_CAUSE_OFS:
                    prdata[pmc_pkg::DS_EXIT_BIT] <= exit_flag_q;
                pmc_pkg::SCRATCH_A_OFS:
                    prdata[pmc_pkg::SCRATCH_W-1:0] <= scratch_a_q;
                pmc_pkg::SCRATCH_B_OFS:
                    prdata[pmc_pkg::SCRATCH_W-1:0] <= scratch_b_q;
                pmc_pkg::STATUS_OFS: prdata[2:0] <= state_q;
                default: prdata <= pmc_pkg::RDATA_RST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake conditions
    // Asserting level follows the configured edge polarity
    assign ext_assert = (ext_irq_zero == ext_irq_zero_pol);
    // Only a change into the asserting level inside Deep Sleep counts
    assign ext_wake = ext_en_q && ext_assert &&
                      (ext_prev_q != ext_irq_zero);
    // Retention is lost only with the brownout circuit configured
    assign ds_lost = deep_brownout_cfg_enable &&
                     (brownout_event || supply_por);
    assign ds_wake = supply_por || ds_watchdog_timeout ||
                     (calendar_alarm && calendar_enable) ||
                     !master_clear_pin_n || ext_wake;
    assign sleep_wake = irq_pending || wdt_timeout;
    assign ds_entry = (state_q == pmc_pkg::ST_ENTER) && !idle_sel_q &&
                      arm_q;

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            pmc_pkg::ST_RUN: begin
                if (power_save_instruction) begin
                    state_d = pmc_pkg::ST_ENTER;
                end
            end
            // Entry completes before any wake is honoured
            pmc_pkg::ST_ENTER: begin
                if (idle_sel_q) begin
                    state_d = pmc_pkg::ST_IDLE;
                end else if (arm_q) begin
                    state_d = pmc_pkg::ST_DSLEEP;
                end else begin
                    state_d = pmc_pkg::ST_SLEEP;
                end
            end
            pmc_pkg::ST_SLEEP, pmc_pkg::ST_IDLE: begin
                if (sleep_wake) begin
                    state_d = pmc_pkg::ST_RUN;
                end
            end
            pmc_pkg::ST_DSLEEP: begin
                if (ds_wake) begin
                    state_d = pmc_pkg::ST_DSPOR;
                end
            end
            pmc_pkg::ST_DSPOR: begin
                if (por_cnt_q == pmc_pkg::POR_SEQ_LAST) begin
                    state_d = pmc_pkg::ST_RUN;
                end
            end
            default: state_d = pmc_pkg::ST_RUN;
        endcase
    end

    // Any device reset wakes the sequencer straight into run
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= pmc_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Operand decoded when the instruction is taken
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            idle_sel_q <= 1'b0;
            clk_src_q <= 3'h0;
        end else if (state_q == pmc_pkg::ST_RUN &&
                     power_save_instruction) begin
            idle_sel_q <= (save_operand != 8'h00);
            clk_src_q <= clk_src_sel;
        end
    end

    // Reset sequence length after a Deep Sleep exit
    always_ff @(posedge ref_clk) begin
        if (rst || state_q != pmc_pkg::ST_DSPOR) begin
            por_cnt_q <= 8'h00;
        end else begin
            por_cnt_q <= por_cnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Deep Sleep arming; the window covers the three no-ops and the
    // instruction, so a stray write cannot leave the device armed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arm_q <= 1'b0;
            arm_cnt_q <= 4'h0;
        end else if (state_q == pmc_pkg::ST_DSPOR) begin
            arm_q <= 1'b0;
        end else if (wr_ctrl && pwdata[pmc_pkg::ARM_BIT]) begin
            arm_q <= 1'b1;
            arm_cnt_q <= 4'h0;
        end else if (wr_ctrl) begin
            arm_q <= 1'b0;
        end else if (arm_q && state_q == pmc_pkg::ST_RUN) begin
            if (power_save_instruction) begin
                arm_cnt_q <= 4'h0;
            end else if (arm_cnt_q == pmc_pkg::ARM_WIN_LAST) begin
                arm_q <= 1'b0;
            end else begin
                arm_cnt_q <= arm_cnt_q + 4'h1;
            end
        end
    end

    // External irq enable and level captured at entry
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_en_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else if (ds_entry) begin
            ext_en_q <= ext_irq_zero_en;
            ext_prev_q <= ext_irq_zero;
        end else begin
            ext_prev_q <= ext_irq_zero;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: recorded only in Deep Sleep, by the event that ends it or by a brownout
    assign ws_set[pmc_pkg::WS_POR] = supply_por;
    assign ws_set[pmc_pkg::WS_CLR_PIN] = !master_clear_pin_n;
    assign ws_set[pmc_pkg::WS_DS_WDOG] = ds_watchdog_timeout;
    assign ws_set[pmc_pkg::WS_ALARM] = calendar_alarm && calendar_enable;
    assign ws_set[pmc_pkg::WS_EXTIRQ] = ext_wake;

    // Setting the arm bit wipes the wake sources
    for (genvar i = 0; i < pmc_pkg::WS_NUM; i++) begin : g_ws
        pmc_flag u_ws (
            .ref_clk(ref_clk),
            .rst(rst),
            .set(state_q == pmc_pkg::ST_DSLEEP && ws_set[i]),
            .clr(wr_ctrl && pwdata[pmc_pkg::ARM_BIT]),
            .q(ws_q[i])
        );
    end

    // Exit flag cleared by writing zero to its bit
    pmc_flag u_exit (
        .ref_clk(ref_clk),
        .rst(rst),
        .set(state_q == pmc_pkg::ST_DSLEEP && ds_wake),
        .clr(wr_en && paddr == pmc_pkg::RST_CAUSE_OFS &&
             !pwdata[pmc_pkg::DS_EXIT_BIT]),
        .q(exit_flag_q)
    );

    pmc_flag u_bor (
        .ref_clk(ref_clk),
        .rst(rst),
        .set(state_q == pmc_pkg::ST_DSLEEP && brownout_event &&
             deep_brownout_cfg_enable),
        .clr(wr_ctrl && !pwdata[pmc_pkg::BROWNOUT_BIT]),
        .q(bor_flag_q)
    );

    // Unfreeze bit: hardware sets on entry, software can only clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            unfreeze_q <= 1'b0;
        end else if (ds_entry) begin
            unfreeze_q <= 1'b1;
        end else if (state_q == pmc_pkg::ST_DSLEEP && ds_lost) begin
            unfreeze_q <= 1'b0;
        end else if (wr_ctrl && !pwdata[pmc_pkg::UNFREEZE_BIT]) begin
            unfreeze_q <= 1'b0;
        end
    end

    // Scratch survives Deep Sleep exit but not a lost-retention event
    always_ff @(posedge ref_clk) begin
        if (rst || (state_q == pmc_pkg::ST_DSLEEP && ds_lost)) begin
            scratch_a_q <= pmc_pkg::SCRATCH_RST;
            scratch_b_q <= pmc_pkg::SCRATCH_RST;
        end else if (wr_en && paddr == pmc_pkg::SCRATCH_A_OFS) begin
            scratch_a_q <= pwdata[pmc_pkg::SCRATCH_W-1:0];
        end else if (wr_en && paddr == pmc_pkg::SCRATCH_B_OFS) begin
            scratch_b_q <= pwdata[pmc_pkg::SCRATCH_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock, power and pin control outputs
    always_comb begin
        sys_clk_en = !(state_q == pmc_pkg::ST_SLEEP ||
                       state_q == pmc_pkg::ST_DSLEEP);
        cpu_clk_en = (state_q == pmc_pkg::ST_RUN);
        periph_clk_en = sys_clk_en;
        mem_power_en = (state_q != pmc_pkg::ST_DSLEEP);
        case (state_q)
            pmc_pkg::ST_SLEEP: low_power_osc_run = wdt_enable ||
                (calendar_enable && calendar_on_lpo);
            pmc_pkg::ST_IDLE: low_power_osc_run = wdt_enable ||
                clock_fail_monitor_en;
            pmc_pkg::ST_DSLEEP: low_power_osc_run = ds_watchdog_enable ||
                (calendar_enable && calendar_on_lpo);
            default: low_power_osc_run = 1'b1;
        endcase
    end

    // Pins stay frozen through the reset sequence until unfreeze clears;
    // a lost-retention event in Deep Sleep drops the bit and frees them
    assign io_freeze = (state_q == pmc_pkg::ST_SLEEP) ||
                       unfreeze_q;
    assign wdt_clear = (state_q == pmc_pkg::ST_ENTER) &&
                       (wdt_enable || idle_sel_q);
    assign irq_holdoff = (state_q == pmc_pkg::ST_ENTER);
    assign irq_discard = ds_entry;
    assign cpu_reset = (state_q == pmc_pkg::ST_DSPOR);
    assign resume_clk_src = clk_src_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_take;
        state_q == pmc_pkg::ST_RUN && power_save_instruction;
    endsequence
    sequence s_enter_sleep;
        state_q == pmc_pkg::ST_ENTER ##1 state_q == pmc_pkg::ST_SLEEP;
    endsequence

    sleep_clk_off_a: assert property (state_q == pmc_pkg::ST_SLEEP
        |-> !sys_clk_en && !cpu_clk_en && io_freeze)
        else $error("clock or pins active in sleep");
    entry_wdt_clr_a: assert property (s_take ##1 wdt_enable
        |-> wdt_clear)
        else $error("watchdog not cleared on entry");
    sleep_wake_a: assert property (state_q == pmc_pkg::ST_SLEEP &&
        irq_pending |=> state_q == pmc_pkg::ST_RUN && cpu_clk_en)
        else $error("sleep did not wake on interrupt");
    clk_src_a: assert property (s_take |=> resume_clk_src ==
        $past(clk_src_sel))
        else $error("clock source not captured");
    idle_clk_a: assert property (state_q == pmc_pkg::ST_IDLE
        |-> sys_clk_en && !cpu_clk_en)
        else $error("idle clock gating wrong");
    // Deep Sleep entry is left out: interrupts do not wake it
    holdoff_a: assert property (s_take ##1 irq_pending && !ds_entry
        |-> irq_holdoff ##1 state_q != pmc_pkg::ST_RUN ##1
        state_q == pmc_pkg::ST_RUN)
        else $error("held-off interrupt did not wake");
    arm_timeout_a: assert property ($rose(arm_q) &&
        !power_save_instruction ##1 (!power_save_instruction && !wr_ctrl &&
        state_q == pmc_pkg::ST_RUN)[*4] |-> !arm_q)
        else $error("arm bit not cleared after window");
    arm_exit_a: assert property (state_q == pmc_pkg::ST_DSPOR
        |=> !arm_q)
        else $error("arm bit kept after exit");
    ws_clear_a: assert property (wr_ctrl && pwdata[pmc_pkg::ARM_BIT]
        |=> ws_q == '0)
        else $error("wake flags not cleared on arm");
    ds_exit_a: assert property (state_q == pmc_pkg::ST_DSLEEP &&
        ds_wake |=> exit_flag_q && cpu_reset ##[1:40]
        state_q == pmc_pkg::ST_RUN)
        else $error("deep sleep exit sequence wrong");
    ds_power_a: assert property (state_q == pmc_pkg::ST_DSLEEP
        |-> !mem_power_en && (io_freeze || bor_flag_q))
        else $error("memory powered in deep sleep");
    ds_release_a: assert property (state_q == pmc_pkg::ST_DSLEEP &&
        ds_lost |=> !io_freeze && scratch_a_q == pmc_pkg::SCRATCH_RST)
        else $error("pins or retention kept after brownout");
    unfreeze_a: assert property (state_q == pmc_pkg::ST_DSPOR &&
        $past(io_freeze) && !$past(ds_lost) |-> io_freeze)
        else $error("pins released during reset sequence");
    sleep_path_a: assert property (s_take ##1 !idle_sel_q && !arm_q
        |-> s_enter_sleep)
        else $error("zero operand did not enter sleep");
endmodule
`default_nettype wire

/* File: hdl/pmc_pkg.sv */
`default_nettype none
package pmc_pkg;
    // Register byte offsets
    localparam logic [7:0] DS_CTRL_OFS = 8'h00;
    localparam logic [7:0] WAKE_SRC_OFS = 8'h04;
    localparam logic [7:0] RST_CAUSE_OFS = 8'h08;
    localparam logic [7:0] SCRATCH_A_OFS = 8'h0C;
    localparam logic [7:0] SCRATCH_B_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    // Field positions in deep_sleep_control
    localparam int ARM_BIT = 15;
    localparam int BROWNOUT_BIT = 1;
    localparam int UNFREEZE_BIT = 0;
    // Field position in reset_cause_reg
    localparam int DS_EXIT_BIT = 10;
    // Wake source flag positions
    localparam int WS_POR = 0;
    localparam int WS_CLR_PIN = 1;
    localparam int WS_DS_WDOG = 2;
    localparam int WS_ALARM = 3;
    localparam int WS_EXTIRQ = 4;
    localparam int WS_NUM = 5;
    localparam int SCRATCH_W = 16;
    // Reset values
    localparam logic [SCRATCH_W-1:0] SCRATCH_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    // Timing: clock period, instruction cycle, arming window, reset sequence
    localparam int CLK_NS = 50;
    localparam int INSTR_NS = 50;
    localparam int INSTR_CYC = (INSTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int ARM_WIN_INSTR = 4;
    localparam int ARM_WIN_CYC = ARM_WIN_INSTR * INSTR_CYC;
    localparam int POR_SEQ_NS = 1000;
    localparam int POR_SEQ_CYC = (POR_SEQ_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] ARM_WIN_LAST = 4'(ARM_WIN_CYC - 1);
    localparam logic [7:0] POR_SEQ_LAST = 8'(POR_SEQ_CYC - 1);
    // Controller states
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_ENTER = 3'h1,
        ST_SLEEP = 3'h2,
        ST_IDLE = 3'h3,
        ST_DSLEEP = 3'h4,
        ST_DSPOR = 3'h5
    } pmc_state_t;
endpackage
`default_nettype wire

/* File: hdl/pmc_flag.sv */
`default_nettype none
// Sticky flag: hardware set wins over a clear in the same cycle
module pmc_flag (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb/pmc_cpu_model.sv */
`default_nettype none
// CPU side: runs the firmware no-ops, then the power-save instruction
module pmc_cpu_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [7:0] op,
    input wire logic [1:0] nops,
    output logic power_save_instruction,
    output logic [7:0] save_operand
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_q;
    logic busy_q;
    initial begin
        power_save_instruction = 1'h0;
        save_operand = 8'hA5;
        cnt_q = 2'h0;
        busy_q = 1'h0;
    end
    // Operand means nothing outside the pulse, so it wanders there
    always @(posedge ref_clk) begin
        power_save_instruction <= 1'h0;
        save_operand <= ~save_operand;
        if (go && !busy_q) begin
            if (nops < 2'h2) begin
                power_save_instruction <= 1'h1;
                save_operand <= op;
            end else begin
                cnt_q <= nops - 2'h1;
                busy_q <= 1'h1;
            end
        end else if (busy_q) begin
            if (cnt_q == 2'h1) begin
                // Last no-op done: lands just inside the arm window
                power_save_instruction <= 1'h1;
                save_operand <= op;
                busy_q <= 1'h0;
            end else begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, go = 1'h0, irq_pending = 1'h0, wdt_enable = 1'h0;
    logic wdt_timeout = 1'h0, calendar_enable = 1'h0, calendar_on_lpo = 1'h0;
    logic calendar_alarm = 1'h0, clock_fail_monitor_en = 1'h0;
    logic ds_watchdog_enable = 1'h0, ds_watchdog_timeout = 1'h0;
    logic supply_por = 1'h0, brownout_event = 1'h0;
    logic deep_brownout_cfg_enable = 1'h0, master_clear_pin_n = 1'h1;
    logic ext_irq_zero = 1'h0, ext_irq_zero_en = 1'h0, ext_irq_zero_pol = 1'h1;
    logic pready, pslverr, power_save_instruction, sys_clk_en, cpu_clk_en;
    logic periph_clk_en, low_power_osc_run, io_freeze, mem_power_en;
    logic wdt_clear, irq_holdoff, irq_discard, cpu_reset, err;
    logic [7:0] paddr = 8'h00, op = 8'h00, save_operand;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] clk_src_sel = 3'h0, resume_clk_src;
    logic [1:0] nops = 2'h0;
    int n_mismatch = 0, check_count = 0, cyc = 0, n;

    pmc_ctrl pmc_ctrl_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .power_save_instruction,
        .save_operand, .clk_src_sel, .irq_pending, .wdt_enable, .wdt_timeout,
        .calendar_enable, .calendar_on_lpo, .calendar_alarm,
        .clock_fail_monitor_en, .ds_watchdog_enable, .ds_watchdog_timeout,
        .supply_por, .brownout_event, .deep_brownout_cfg_enable,
        .master_clear_pin_n, .ext_irq_zero, .ext_irq_zero_en,
        .ext_irq_zero_pol, .sys_clk_en, .cpu_clk_en, .periph_clk_en,
        .low_power_osc_run, .io_freeze, .mem_power_en, .wdt_clear,
        .irq_holdoff, .irq_discard, .cpu_reset, .resume_clk_src);
    pmc_cpu_model pmc_cpu_model_i (.ref_clk, .go, .op, .nops,
        .power_save_instruction, .save_operand);

    always #25 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: check %0d got %h expected %h",
                $time, check_count, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        @(posedge ref_clk);
        while (pready !== 1'h1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Ask the CPU model for the instruction; returns settled in ENTER
    task automatic fire(input logic [7:0] o, input logic [1:0] k);
        go <= 1'h1;
        op <= o;
        nops <= k;
        @(posedge ref_clk);
        go <= 1'h0;
        while (power_save_instruction !== 1'h1) @(posedge ref_clk);
        #1;
    endtask

    // Hang guard: far above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'h0;
        #1 chk(32'({sys_clk_en, cpu_clk_en, periph_clk_en, low_power_osc_run,
            io_freeze, mem_power_en, cpu_reset, pready}), 32'hF5);
        // Idle controller after reset, then a refused access
        apb(1'h0, pmc_pkg::STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 8'h40, 32'h0);
        chk(32'(err), 32'h1);
        // Sleep with watchdog on; entry clock source must come back
        wdt_enable <= 1'h1;
        clk_src_sel <= 3'h5;
        fire(8'h00, 2'h0);
        chk(32'({cpu_clk_en, wdt_clear, irq_holdoff, irq_discard}),
            32'h6);
        @(posedge ref_clk);
        irq_pending <= 1'h1;
        clk_src_sel <= 3'h2;
        #1 chk(32'({sys_clk_en, cpu_clk_en, periph_clk_en, low_power_osc_run,
            io_freeze}), 32'h3);
        @(posedge ref_clk);
        irq_pending <= 1'h0;
        #1 chk(32'({cpu_clk_en, resume_clk_src}), 32'hD);
        // Idle: the clock monitor keeps the slow oscillator alive
        @(posedge ref_clk);
        wdt_enable <= 1'h0;
        clock_fail_monitor_en <= 1'h1;
        fire(8'h01, 2'h0);
        chk(32'({cpu_clk_en, wdt_clear}), 32'h1);
        @(posedge ref_clk);
        wdt_timeout <= 1'h1;
        #1 chk(32'({sys_clk_en, cpu_clk_en, periph_clk_en,
            low_power_osc_run}), 32'hB);
        @(posedge ref_clk);
        wdt_timeout <= 1'h0;
        #1 chk(32'(cpu_clk_en), 32'h1);
        // Interrupt together with the instruction: entry ends, then wakes
        @(posedge ref_clk);
        irq_pending <= 1'h1;
        fire(8'h00, 2'h0);
        chk(32'(irq_holdoff), 32'h1);
        @(posedge ref_clk);
        #1 chk(32'(sys_clk_en), 32'h0);
        @(posedge ref_clk);
        #1 chk(32'({sys_clk_en, cpu_clk_en}), 32'h3);
        // Deep Sleep once per wake source; i is that source's flag bit
        apb(1'h1, pmc_pkg::SCRATCH_A_OFS, 32'h1234);
        calendar_enable <= 1'h1;
        ext_irq_zero_en <= 1'h1;
        ds_watchdog_enable <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, pmc_pkg::DS_CTRL_OFS, 32'h8000);
            fire(8'h00, 2'h3);
            chk(32'({cpu_clk_en, wdt_clear, irq_discard}), 32'h1);
            @(posedge ref_clk);
            #1 chk(32'({sys_clk_en, cpu_clk_en, periph_clk_en, io_freeze,
                mem_power_en}), 32'h2);
            @(posedge ref_clk);
            supply_por <= (i == 0);
            master_clear_pin_n <= (i != 1);
            ds_watchdog_timeout <= (i == 2);
            calendar_alarm <= (i == 3);
            ext_irq_zero <= (i == 4);
            // A late event during the reset sequence must leave no trace
            @(posedge ref_clk);
            supply_por <= 1'h0;
            master_clear_pin_n <= 1'h1;
            ds_watchdog_timeout <= (i == 1);
            calendar_alarm <= 1'h0;
            ext_irq_zero <= 1'h0;
            n = 0;
            #1;
            while (cpu_reset === 1'h1 && n < 99) begin
                n++;
                @(posedge ref_clk);
                #1;
            end
            chk(32'(n), 32'(pmc_pkg::POR_SEQ_CYC));
            chk(32'(io_freeze), 32'h1);
            apb(1'h0, pmc_pkg::DS_CTRL_OFS, 32'h0);
            ds_watchdog_timeout <= 1'h0;
            chk(rd, 32'h1);
            apb(1'h0, pmc_pkg::WAKE_SRC_OFS, 32'h0);
            chk(rd, 32'h1 << i);
            apb(1'h0, pmc_pkg::RST_CAUSE_OFS, 32'h0);
            chk(rd, 32'h400);
            apb(1'h1, pmc_pkg::RST_CAUSE_OFS, 32'h0);
            apb(1'h0, pmc_pkg::RST_CAUSE_OFS, 32'h0);
            chk(rd, 32'h0);
            apb(1'h0, pmc_pkg::SCRATCH_A_OFS, 32'h0);
            chk(rd, 32'h1234);
            apb(1'h1, pmc_pkg::DS_CTRL_OFS, 32'h0);
            #1 chk(32'(io_freeze), 32'h0);
            repeat (3) @(posedge ref_clk);
        end
        // Brownout in Deep Sleep frees pins at once and loses retention
        deep_brownout_cfg_enable <= 1'h1;
        apb(1'h1, pmc_pkg::DS_CTRL_OFS, 32'h8000);
        fire(8'h00, 2'h3);
        @(posedge ref_clk);
        brownout_event <= 1'h1;
        @(posedge ref_clk);
        brownout_event <= 1'h0;
        #1 chk(32'({io_freeze, mem_power_en}), 32'h0);
        @(posedge ref_clk);
        master_clear_pin_n <= 1'h0;
        @(posedge ref_clk);
        master_clear_pin_n <= 1'h1;
        #1 while (cpu_reset === 1'h1) @(posedge ref_clk);
        apb(1'h0, pmc_pkg::DS_CTRL_OFS, 32'h0);
        chk(rd, 32'h2);
        apb(1'h0, pmc_pkg::SCRATCH_A_OFS, 32'h0);
        chk(rd, 32'h0);
        // Arming wipes old flags; with no instruction the arm lapses
        apb(1'h1, pmc_pkg::DS_CTRL_OFS, 32'h8000);
        irq_pending <= 1'h0;
        apb(1'h0, pmc_pkg::WAKE_SRC_OFS, 32'h0);
        chk(rd, 32'h0);
        repeat (6) @(posedge ref_clk);
        apb(1'h0, pmc_pkg::DS_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
